// ---- core/wws_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
module wws_counter
    import wws_pkg::*;
#(
    parameter int unsigned WIDTH = 32
)
(
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             run,
    output logic [WIDTH-1:0]      count
);
    // Counts up while run is high, saturating; clear takes priority.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (run && (count != {WIDTH{1'b1}}))
            count <= count + 1'b1;
    end
endmodule
`default_nettype wire

// ---- core/wws_pkg.sv ----
`default_nettype none
package wws_pkg;
    // Clock rate used to turn times into cycle counts.
    localparam int unsigned CLOCK_MHZ = 200;

    // Reset pulse options, nominal times in nanoseconds.
    localparam int unsigned RESET_TIME_0_NS = 35_000;
    localparam int unsigned RESET_TIME_1_NS = 3_125_000;
    localparam int unsigned RESET_TIME_2_NS = 12_500_000;
    localparam int unsigned RESET_TIME_3_NS = 50_000_000;
    localparam int unsigned RESET_TIME_4_NS = 200_000_000;

    // Slow limit gain in units of 10^6 V/A; seconds = farads times this gain.
    localparam int unsigned CAP_GAIN_MEGA   = 155;
    // Cycles per picofarad: 1e-12 * gain * 1e6 * clock rate.
    localparam logic [31:0] CAP_CYCLES_PER_PF = 32'(CAP_GAIN_MEGA * CLOCK_MHZ);

    // Regulator current thresholds in tenths of a milliampere.
    localparam logic [15:0] CUR_OFF_DMA = 16'h001e;
    localparam logic [15:0] CUR_ON_DMA  = 16'h008a;

    // Window ratio shifts: divide by 8, 16 and 64.
    localparam logic [2:0] SHIFT_R8  = 3'h3;
    localparam logic [2:0] SHIFT_R16 = 3'h4;
    localparam logic [2:0] SHIFT_R64 = 3'h6;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CAP    = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK   = 8'h0c;
    localparam logic [7:0] OFS_STATE  = 8'h10;
    localparam logic [7:0] OFS_TIMER  = 8'h14;

    // Field positions and reset values.
    localparam int unsigned CTRL_WIN_BIT  = 0;
    localparam int unsigned CTRL_SEL_LSB  = 1;
    localparam int unsigned CAP_WIDTH     = 17;
    localparam int unsigned EVT_FAST_BIT  = 0;
    localparam int unsigned EVT_SLOW_BIT  = 1;
    localparam logic [3:0]  CTRL_RESET    = 4'h5;
    localparam logic [CAP_WIDTH-1:0] CAP_RESET = 17'h007d0;
    localparam logic [1:0]  MASK_RESET    = 2'h0;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Software control word.
    typedef struct packed {
        logic [2:0] reset_sel;
        logic       windowed;
    } wws_ctrl_type;

    // Fault events raised by the supervisor.
    typedef struct packed {
        logic slow;
        logic fast;
    } wws_event_type;
endpackage
`default_nettype wire

// ---- core/wws_supervisor.sv ----
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1 - Capacitor mode: slow limit equals capacitance times 155e6 V/A.
// RULE2 - Timing pin tied to regulator output selects the fixed slow limit.
// RULE3 - Two strobe edges closer than the fast limit raise a fast fault.
// RULE4 - No strobe edge within the slow limit raises a slow fault.
// RULE5 - Fast limit is slow limit divided by 8, 16 or 64.
// RULE6 - Select 00 gives 8, 01 gives 16, 11 gives 64, 10 disables.
// RULE7 - Any fault drives reset low for the separately chosen reset time.
// RULE8 - Reset time options: 35us, 3.125ms, 12.5ms, 50ms or 200ms.
// RULE9 - Strobe edges are ignored while reset is asserted.
// RULE10 - Interval timing starts only once reset is released.
// RULE11 - Interval timer clears whenever reset becomes asserted.
// RULE12 - Controller must strobe between the maximum fast and minimum slow limits.
// RULE13 - Windowed variant: select a high, b low disables the watchdog.
// RULE14 - Non-windowed variant: disable input low disables the watchdog.
// RULE15 - Regulator current below 3mA disables the watchdog.
// RULE16 - Watchdog re-enables at once when no disable remains and reset is off.
// RULE17 - Low-current disable has hysteresis; re-enable above 13.8mA.
// RULE18 - Disabled watchdog holds timer cleared, reports no faults, restarts at zero.
module wws_supervisor
    import wws_pkg::*;
#(
    parameter logic [31:0] FIXED_SLOW_CYCLES = 32'd50_000_000,
    parameter logic [31:0] RESET_CYCLES_0    = 32'(RESET_TIME_0_NS / 1000 * CLOCK_MHZ),
    parameter logic [31:0] RESET_CYCLES_1    = 32'(RESET_TIME_1_NS / 1000 * CLOCK_MHZ),
    parameter logic [31:0] RESET_CYCLES_2    = 32'(RESET_TIME_2_NS / 1000 * CLOCK_MHZ),
    parameter logic [31:0] RESET_CYCLES_3    = 32'(RESET_TIME_3_NS / 1000 * CLOCK_MHZ),
    parameter logic [31:0] RESET_CYCLES_4    = 32'(RESET_TIME_4_NS / 1000 * CLOCK_MHZ)
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        watchdog_strobe_in,
    input  wire logic        wd_period_cap_pin,
    input  wire logic        window_ratio_sel_a,
    input  wire logic        window_ratio_sel_b,
    input  wire logic        watchdog_off_n,
    input  wire logic [15:0] load_current_dma,
    output logic             reset_out_n,
    output logic             irq,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    wws_ctrl_type           ctrl;
    logic [CAP_WIDTH-1:0]   cap_pf;
    wws_event_type          status;
    wws_event_type          mask;
    wws_event_type          fault;
    logic                   reset_active;
    logic                   wd_enabled;
    logic                   low_current;
    logic                   strobe_prev;
    logic [31:0]            slow_limit;
    logic [31:0]            fast_limit;
    logic [31:0]            reset_pulse_time;
    logic [31:0]            interval;
    logic [31:0]            pulse_count;
    logic                   disable_cond;
    logic                   edge_seen;
    logic                   aw_held;
    logic                   w_held;
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   do_write;
    logic                   status_read;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;

    // Slow limit from the timing capacitor or the fixed internal value.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            slow_limit <= '0;
        else if (wd_period_cap_pin)
            slow_limit <= FIXED_SLOW_CYCLES;                      // RULE2
        else
            slow_limit <= 32'(cap_pf) * CAP_CYCLES_PER_PF;      // RULE1
    end

    // Fast limit as slow limit over the selected window ratio.
    always_comb
    begin
        case ({window_ratio_sel_a, window_ratio_sel_b})          // RULE6
            2'b00:   fast_limit = slow_limit >> SHIFT_R8;        // RULE5
            2'b01:   fast_limit = slow_limit >> SHIFT_R16;
            2'b11:   fast_limit = slow_limit >> SHIFT_R64;
            default: fast_limit = '0;
        endcase
    end

    // Reset pulse length chosen by the reset_sel control field.
    always_comb
    begin
        case (ctrl.reset_sel)                                    // RULE8
            3'h0:    reset_pulse_time = RESET_CYCLES_0;
            3'h1:    reset_pulse_time = RESET_CYCLES_1;
            3'h2:    reset_pulse_time = RESET_CYCLES_2;
            3'h3:    reset_pulse_time = RESET_CYCLES_3;
            default: reset_pulse_time = RESET_CYCLES_4;
        endcase
    end

    // Low-current detector with hysteresis between the two thresholds.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            low_current <= 1'b0;
        else if (load_current_dma < CUR_OFF_DMA)
            low_current <= 1'b1;                                 // RULE15
        else if (load_current_dma > CUR_ON_DMA)
            low_current <= 1'b0;                                 // RULE17
    end

    // Any of the disable paths, depending on the variant.
    assign disable_cond = low_current
        || (ctrl.windowed && window_ratio_sel_a && !window_ratio_sel_b)  // RULE13
        || (!ctrl.windowed && !watchdog_off_n);                          // RULE14

    // Enable drops at once and returns only while reset is released.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            wd_enabled <= 1'b0;
        else if (disable_cond)
            wd_enabled <= 1'b0;
        else if (!reset_active)
            wd_enabled <= 1'b1;                                  // RULE16
    end

    // Strobe history; tracked during reset so held edges are dropped.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            strobe_prev <= 1'b0;
        else
            strobe_prev <= watchdog_strobe_in;
    end

    assign edge_seen = (watchdog_strobe_in != strobe_prev) && !reset_active;  // RULE9

    // Fault detection, only while enabled and out of reset.
    always_comb
    begin
        fault.fast = 1'b0;
        fault.slow = 1'b0;
        if (wd_enabled && !reset_active)                         // RULE18
        begin
            fault.fast = ctrl.windowed && edge_seen && (interval < fast_limit);  // RULE3
            fault.slow = !edge_seen && (interval >= slow_limit);                 // RULE4
        end
    end

    // Interval timer: restarts on every edge, held clear in reset or disable.
    wws_counter #(
        .WIDTH (32)
    ) u_interval (
        .clock (clock),
        .rst_n (rst_n),
        .clear (reset_active || !wd_enabled || edge_seen),       // RULE11 RULE18
        .run   (1'b1),                                           // RULE10
        .count (interval)
    );

    // Reset pulse timer runs only while reset is driven.
    wws_counter #(
        .WIDTH (32)
    ) u_pulse (
        .clock (clock),
        .rst_n (rst_n),
        .clear (!reset_active),
        .run   (reset_active),
        .count (pulse_count)
    );

    // Reset output: asserted on a fault, released after the pulse time.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reset_active <= 1'b0;
        else if (fault.fast || fault.slow)
            reset_active <= 1'b1;                                // RULE7
        else if (reset_active && (pulse_count >= reset_pulse_time - 32'h1))
            reset_active <= 1'b0;
    end

    // Output pin is a flop of the reset state or a fault raised this cycle.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reset_out_n <= 1'b1;
        else
            reset_out_n <= !(reset_active || fault.fast || fault.slow);  // RULE7
    end

    // Write channel capture: address and data may come in either order.
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held <= 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
            w_held <= 1'b0;
    end

    // Ready flops: each channel accepts one item until the write completes.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                OFS_CTRL, OFS_CAP, OFS_STATUS, OFS_MASK, OFS_STATE, OFS_TIMER:
                    s_axi_bresp <= RESP_OKAY;
                default:
                    s_axi_bresp <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Writable registers; ctrl and mask from byte lane 0, cap from lanes 0 to 2.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl   <= CTRL_RESET;
            cap_pf <= CAP_RESET;
            mask   <= MASK_RESET;
        end
        else if (do_write)
        begin
            if (aw_addr == OFS_CTRL && w_strb[0])
                ctrl <= w_data[CTRL_SEL_LSB+2:CTRL_WIN_BIT];
            if (aw_addr == OFS_CAP)
            begin
                if (w_strb[0])
                    cap_pf[7:0] <= w_data[7:0];
                if (w_strb[1])
                    cap_pf[15:8] <= w_data[15:8];
                if (w_strb[2])
                    cap_pf[16] <= w_data[16];
            end
            if (aw_addr == OFS_MASK && w_strb[0])
                mask <= w_data[EVT_SLOW_BIT:EVT_FAST_BIT];
        end
    end

    // Read data mux.
    always_comb
    begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        case (s_axi_araddr)
            OFS_CTRL:   next_rdata = 32'(ctrl);
            OFS_CAP:    next_rdata = 32'(cap_pf);
            OFS_STATUS: next_rdata = 32'(status);
            OFS_MASK:   next_rdata = 32'(mask);
            OFS_STATE:  next_rdata = {28'h0000000, low_current, disable_cond,
                                      wd_enabled, reset_active};
            OFS_TIMER:  next_rdata = interval;
            default:    next_rresp = RESP_SLVERR;
        endcase
    end

    assign status_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == OFS_STATUS);

    // Read channel: one beat answered the cycle after the address is taken.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // Sticky fault status; a read clears it but a new fault wins.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            status <= '0;
        else
            status <= (status_read ? wws_event_type'(2'h0) : status) | fault;
    end

    // Level interrupt from unmasked status bits.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end
endmodule
`default_nettype wire

// ---- verification/windowed_watchdog_supervisor_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_supervisor_bench
    import wws_pkg::*;
;
    localparam int SLOW    = 2000;
    localparam int TIMEOUT = 95000;
    localparam int PULSE[5] = '{20, 30, 40, 50, 60};
    logic        clock, rst_n, watchdog_strobe_in, wd_period_cap_pin, window_ratio_sel_a;
    logic        window_ratio_sel_b, watchdog_off_n, reset_out_n, irq;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [15:0] load_current_dma;
    logic [31:0] s_axi_wdata, s_axi_rdata, gap, rd;
    int          num_errors, checks, cycles, n, k, fast;
    int          divs[3] = '{8, 16, 64};
    logic [1:0]  sels[3] = '{2'h0, 2'h1, 2'h3};

    wws_supervisor #(
        .FIXED_SLOW_CYCLES(32'(SLOW)), .RESET_CYCLES_0(32'(PULSE[0])), .RESET_CYCLES_1(32'(PULSE[1])),
        .RESET_CYCLES_2(32'(PULSE[2])), .RESET_CYCLES_3(32'(PULSE[3])), .RESET_CYCLES_4(32'(PULSE[4]))
    ) wws_supervisor_i (
        .clock, .rst_n, .watchdog_strobe_in, .wd_period_cap_pin, .window_ratio_sel_a,
        .window_ratio_sel_b, .watchdog_off_n, .load_current_dma, .reset_out_n, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    wws_strobe_model wws_strobe_model_i (.clock, .rst_n, .host_reset_n(reset_out_n), .gap,
        .strobe(watchdog_strobe_in));

    // Compares a seen value with the expected one and counts both outcomes.
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Checks that a cycle count falls inside a window.
    task near(input string what, input int seen, input int lo, input int hi);
        check(what, 32'(seen >= lo && seen <= hi), 32'h1);
    endtask

    // Writes one word; bready stands until bvalid.
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Reads one word; rready stands until rvalid.
    task axi_read(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clock); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge clock);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Reads a register and compares data and response.
    task read_expect(input string what, input logic [7:0] a, input logic [31:0] exp);
        axi_read(a);
        check(what, rd, exp);
        check("read response", 32'(resp), 32'(RESP_OKAY));
    endtask

    // Counts cycles until the reset output shows a level, at most limit.
    task wait_level(input logic lvl, input int limit);
        n = 0;
        while (n < limit && reset_out_n !== lvl)
        begin
            @(posedge clock);
            n++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task give_verdict();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Free-running clock at 200 MHz.
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cuts a hung run short.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == TIMEOUT)
        begin
            num_errors++;
            give_verdict();
        end
    end

    // Main sequence of tests.
    initial
    begin
        {rst_n, window_ratio_sel_a, window_ratio_sel_b, s_axi_awvalid, s_axi_wvalid} = 5'h0;
        {wd_period_cap_pin, watchdog_off_n, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h18;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        load_current_dma = 16'hc8;
        gap = 32'd1000;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        read_expect("ctrl reset", OFS_CTRL, 32'(CTRL_RESET));
        read_expect("cap reset", OFS_CAP, 32'(CAP_RESET));
        read_expect("mask reset", OFS_MASK, 32'(MASK_RESET));
        axi_read(8'h20);
        check("unmapped data", rd, 32'h0);
        check("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
        axi_write(8'h20, 32'h3);
        check("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
        axi_write(OFS_MASK, 32'h3);
        check("bresp", 32'(resp), 32'(RESP_OKAY));
        read_expect("mask", OFS_MASK, 32'h3);
        $display("registers done");
        wait_level(1'b0, 6000);
        check("steady strobe", 32'(n), 32'd6000);
        $display("steady strobe done");
        for (k = 0; k < 5; k++)
        begin
            wait_level(1'b1, 100);
            axi_write(OFS_CTRL, 32'((k << 1) | 1));
            gap <= 32'h0;
            wait_level(1'b0, 2100);
            wait_level(1'b1, 100);
            near("pulse length", n, PULSE[k] - 1, PULSE[k] + 2);
            wait_level(1'b0, 2100);
            near("slow limit", n, SLOW - 2, SLOW + 4);
            repeat (3) @(posedge clock);
            check("irq raised", 32'(irq), 32'h1);
            read_expect("status slow", OFS_STATUS, 32'h2);
            read_expect("status cleared", OFS_STATUS, 32'h0);
            check("irq cleared", 32'(irq), 32'h0);
        end
        wait_level(1'b1, 100);
        gap <= 32'd1000;
        $display("slow faults done");
        for (k = 0; k < 3; k++)
        begin
            fast = SLOW / divs[k];
            wait_level(1'b1, 100);
            {window_ratio_sel_a, window_ratio_sel_b} <= sels[k];
            gap <= 32'(fast + 5);
            axi_read(OFS_STATUS);
            wait_level(1'b0, 12 * fast);
            check("window open", 32'(n), 32'(12 * fast));
            gap <= 32'(fast - 5);
            wait_level(1'b0, 2 * fast);
            gap <= 32'(fast + 5);
            check("fast caught", 32'(n < 2 * fast), 32'h1);
            read_expect("status fast", OFS_STATUS, 32'h1);
        end
        $display("window ratios done");
        wait_level(1'b1, 100);
        {window_ratio_sel_a, window_ratio_sel_b} <= 2'h2;
        gap <= 32'h0;
        wait_level(1'b0, 3000);
        check("ratio select off", 32'(n), 32'd3000);
        {window_ratio_sel_a, window_ratio_sel_b} <= 2'h0;
        load_current_dma <= 16'h14;
        wait_level(1'b0, 3000);
        check("low current off", 32'(n), 32'd3000);
        read_expect("state", OFS_STATE, 32'hc);
        load_current_dma <= 16'h64;
        wait_level(1'b0, 3000);
        check("current hysteresis", 32'(n), 32'd3000);
        load_current_dma <= 16'hc8;
        wait_level(1'b0, 2100);
        near("restart from zero", n, SLOW - 2, SLOW + 5);
        wait_level(1'b1, 100);
        axi_write(OFS_CTRL, 32'h4);
        watchdog_off_n <= 1'b0;
        wait_level(1'b0, 3000);
        check("disable input off", 32'(n), 32'd3000);
        watchdog_off_n <= 1'b1;
        wait_level(1'b0, 2100);
        near("disable removed", n, SLOW - 2, SLOW + 5);
        wait_level(1'b1, 100);
        axi_write(OFS_CTRL, 32'h5);
        $display("disables done");
        window_ratio_sel_a <= 1'b1;
        wd_period_cap_pin <= 1'b0;
        axi_write(OFS_CAP, 32'h1);
        read_expect("cap", OFS_CAP, 32'h1);
        window_ratio_sel_a <= 1'b0;
        wait_level(1'b0, 32000);
        near("cap slow limit", n, 155 * 200 - 2, 155 * 200 + 5);
        $display("capacitor mode done");
        give_verdict();
    end
endmodule

bind wws_supervisor wws_assertions wws_assertions_i (.clock, .rst_n, .load_current_dma,
    .reset_out_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- verification/wws_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module wws_assertions
    import wws_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [15:0] load_current_dma,
    input wire logic        reset_out_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    logic cur_low;
    // Flags a regulator current below the disable threshold.
    assign cur_low = load_current_dma < CUR_OFF_DMA;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Both write channels taken at one edge.
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Read address taken.
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_pulse_min_width: assert property ($fell(reset_out_n) |-> !reset_out_n [*8])
        else $error("reset pulse ended too soon");
    chk_low_current_quiet:
        assert property (cur_low && $past(cur_low) && $past(cur_low, 2) && $past(cur_low, 3)
            |-> !$fell(reset_out_n)) else $error("reset raised while current was low");
    chk_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (read_taken |=> s_axi_rvalid)
        else $error("read data missing");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule
`default_nettype wire

// ---- verification/wws_strobe_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module wws_strobe_model
    import wws_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        host_reset_n,
    input  wire logic [31:0] gap,
    output logic             strobe
);
    logic [31:0] count;
    // Toggles the strobe every gap cycles; a held host reset or a zero gap stops it.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count  <= 32'h0;
            strobe <= 1'b0;
        end
        else if (!host_reset_n || gap == 32'h0)
            count <= 32'h0;
        else if (count + 32'h1 >= gap)
        begin
            count  <= 32'h0;
            strobe <= ~strobe;
        end
        else
            count <= count + 32'h1;
    end
endmodule
`default_nettype wire
